// ===== hw/jsd_defines.svh
// constants of the scan and debug port
`ifndef JSD_DEFINES_SVH
`define JSD_DEFINES_SVH
`define JSD_IR_W 4
`define JSD_DR_W 32
`define JSD_IR_RESET 4'h1
`define JSD_IR_CAPTURE 4'h1
`define JSD_OP_EXTEST 4'h0
`define JSD_OP_IDCODE 4'h1
`define JSD_OP_SAMPLE 4'h2
`define JSD_OP_USERCODE 4'h3
`define JSD_OP_CHIP 4'h4
`define JSD_OP_BYPASS 4'hF
`define JSD_SEC_DIS_PORT 0
`define JSD_SEC_DIS_DEBUG 14
`define JSD_SEC_UID_HI 31
`define JSD_SEC_UID_LO 22
`define JSD_UID_W 10
`define JSD_REV_W 16
`define JSD_TRST_MIN_NS 100
`define JSD_CLK_NS 40
`define JSD_TRST_CYC ((`JSD_TRST_MIN_NS + `JSD_CLK_NS - 1) / `JSD_CLK_NS)
`endif

// ===== hw/jsd_pkg.sv
// types of the scan and debug port
package jsd_pkg;
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } jsd_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jsd_scan_in_t;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jsd_scan_out_t;
endpackage

// ===== hw/jsd_port.sv
// scan chain of two boundary-scan ports and the debug sync pin
`timescale 1ns/1ns
`include "jsd_defines.svh"
module jsd_port #(
  parameter logic [10:0] MAKER_ID = 11'h2AA, // arbitrary value
  parameter logic [15:0] PART_NUM = 16'h1234, // arbitrary value
  parameter logic [3:0] VERSION = 4'h0, // arbitrary value
  parameter logic [15:0] SILICON_REV = 16'h0001 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // scan pins, from the host's domain
  input wire jsd_pkg::jsd_scan_in_t scan_in,
  input wire logic trst_n,
  output jsd_pkg::jsd_scan_out_t scan_out,
  // security word and its load state
  input wire logic [31:0] sec_reg,
  input wire logic otp_programmed,
  // boundary cells
  input wire logic [31:0] pins_cap_a,
  input wire logic [31:0] pins_cap_b,
  output logic [31:0] pins_drv_a,
  output logic [31:0] pins_drv_b,
  output logic [3:0] ir_a,
  output logic [3:0] ir_b,
  // chip port toward the tile
  input wire logic chip_tdo,
  output logic chip_sel,
  output logic chip_tms,
  output logic chip_tdi,
  output logic chip_tck,
  // debug sync pin, open drain
  input wire logic dbg_in,
  output logic dbg_out,
  output logic dbg_oe,
  input wire logic dbg_cfg_out,
  input wire logic dbg_cfg_en,
  input wire logic brk_hit,
  output logic dbg_enter
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic tck_d_ff;
  logic trst_s1_ff;
  logic trst_ff;
  logic dbg_s1_ff;
  logic dbg_s2_ff;
  logic [`JSD_UID_W-1:0] uid;
  logic [31:0] idcode;
  logic [31:0] usercode;
  logic [31:0] mid_pins;
  logic tck_rise;
  logic tck_fall;
  logic trst_ok;
  logic tdo_a;
  logic oe_a;
  logic tdo_b;
  logic oe_b;
  logic [31:0] drv_a;
  logic [31:0] drv_b;
  logic [3:0] ira;
  logic [3:0] irb;
  logic out_ff;
  logic hold_ff;
  jsd_pkg::jsd_state_t st_a;
  jsd_pkg::jsd_state_t st_b;

  // ------------------------------------------------------------
  // synchronisers and test clock edges
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      tck_d_ff <= 1'b0;
      trst_s1_ff <= 1'b0;
      trst_ff <= 1'b0;
      dbg_s1_ff <= 1'b1;
      dbg_s2_ff <= 1'b1;
    end else begin
      s1_ff <= {scan_in.tck, scan_in.tms, scan_in.tdi};
      s2_ff <= s1_ff;
      tck_d_ff <= s2_ff[2];
      trst_s1_ff <= trst_n;
      trst_ff <= trst_s1_ff;
      dbg_s1_ff <= dbg_in;
      dbg_s2_ff <= dbg_s1_ff;
    end
  end

  // security bit 0 holds both ports in reset so no tile state can leak
  assign trst_ok = trst_ff && !sec_reg[`JSD_SEC_DIS_PORT];
  assign tck_rise = s2_ff[2] && !tck_d_ff;
  assign tck_fall = !s2_ff[2] && tck_d_ff;

  // ------------------------------------------------------------
  // identity words
  // ------------------------------------------------------------
  assign uid = otp_programmed ? sec_reg[`JSD_SEC_UID_HI:`JSD_SEC_UID_LO] : '0;
  assign idcode = {VERSION, PART_NUM, MAKER_ID, 1'b1};
  assign usercode = {uid, {(32-`JSD_UID_W-`JSD_REV_W){1'b0}}, SILICON_REV};

  // ------------------------------------------------------------
  // two ports in series: host -> a -> b -> host
  // ------------------------------------------------------------
  assign mid_pins = pins_cap_b;

  jsd_tap u_tap_a (
    .clk(clk),
    .rstn(rstn),
    .trst_sync_n(trst_ok),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms(s2_ff[1]),
    .tdi(s2_ff[0]),
    .idcode(idcode),
    .usercode(usercode),
    .bscan_cap(pins_cap_a),
    .chip_tdo(chip_tdo),
    .tdo(tdo_a),
    .tdo_oe(oe_a),
    .ir(ira),
    .bscan_upd(drv_a),
    .state(st_a)
  );

  jsd_tap u_tap_b (
    .clk(clk),
    .rstn(rstn),
    .trst_sync_n(trst_ok),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .tms(s2_ff[1]),
    .tdi(tdo_a),
    .idcode(idcode),
    .usercode(usercode),
    .bscan_cap(mid_pins),
    .chip_tdo(chip_tdo),
    .tdo(tdo_b),
    .tdo_oe(oe_b),
    .ir(irb),
    .bscan_upd(drv_b),
    .state(st_b)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_out <= '0;
      pins_drv_a <= '0;
      pins_drv_b <= '0;
      ir_a <= `JSD_IR_RESET;
      ir_b <= `JSD_IR_RESET;
    end else begin
      scan_out <= '{tdo: tdo_b, tdo_oe: oe_b && oe_a};
      pins_drv_a <= drv_a;
      pins_drv_b <= drv_b;
      ir_a <= ira;
      ir_b <= irb;
    end
  end

  // ------------------------------------------------------------
  // chip port forwarding
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chip_sel <= 1'b0;
      chip_tms <= 1'b1;
      chip_tdi <= 1'b0;
      chip_tck <= 1'b0;
    end else begin
      chip_sel <= trst_ok && (ira == `JSD_OP_CHIP) && (st_a != jsd_pkg::TEST_RESET);
      chip_tms <= s2_ff[1];
      chip_tdi <= s2_ff[0];
      chip_tck <= trst_ok && s2_ff[2];
    end
  end

  // ------------------------------------------------------------
  // debug sync pin
  // ------------------------------------------------------------
  // low is latched until the mode is changed or security bit 14 is set; pin only ever pulls low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_ff <= 1'b0;
    end else if (!dbg_cfg_en || !dbg_cfg_out || sec_reg[`JSD_SEC_DIS_DEBUG]) begin
      hold_ff <= 1'b0;
    end else if (brk_hit) begin
      hold_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_ff <= 1'b0;
      dbg_out <= 1'b0;
      dbg_oe <= 1'b0;
      dbg_enter <= 1'b0;
    end else begin
      out_ff <= hold_ff || (brk_hit && dbg_cfg_en && dbg_cfg_out && !sec_reg[`JSD_SEC_DIS_DEBUG]);
      dbg_out <= 1'b0;
      dbg_oe <= out_ff;
      dbg_enter <= dbg_cfg_en && !dbg_cfg_out && !sec_reg[`JSD_SEC_DIS_DEBUG] && !dbg_s2_ff;
    end
  end
endmodule // jsd_port

// ===== hw/jsd_tap.sv
// one boundary-scan test access port
`timescale 1ns/1ns
`include "jsd_defines.svh"
module jsd_tap #(
  parameter int IR_W = `JSD_IR_W,
  parameter int DR_W = `JSD_DR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic trst_sync_n,
  // test clock edges and pins, already synchronised
  input wire logic tck_rise,
  input wire logic tck_fall,
  input wire logic tms,
  input wire logic tdi,
  // data register contents
  input wire logic [DR_W-1:0] idcode,
  input wire logic [DR_W-1:0] usercode,
  input wire logic [DR_W-1:0] bscan_cap,
  input wire logic chip_tdo,
  // results
  output logic tdo,
  output logic tdo_oe,
  output logic [IR_W-1:0] ir,
  output logic [DR_W-1:0] bscan_upd,
  output jsd_pkg::jsd_state_t state
);
  jsd_pkg::jsd_state_t nxt_state;
  logic [IR_W-1:0] ir_sh_ff;
  logic [DR_W-1:0] dr_sh_ff;
  logic byp_ff;
  logic long_sel;

  // ------------------------------------------------------------
  // controller
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state;
    unique case (state)
      jsd_pkg::TEST_RESET: nxt_state = tms ? jsd_pkg::TEST_RESET : jsd_pkg::RUN_IDLE;
      jsd_pkg::RUN_IDLE: nxt_state = tms ? jsd_pkg::SEL_DR : jsd_pkg::RUN_IDLE;
      jsd_pkg::SEL_DR: nxt_state = tms ? jsd_pkg::SEL_IR : jsd_pkg::CAP_DR;
      jsd_pkg::CAP_DR: nxt_state = tms ? jsd_pkg::EXIT1_DR : jsd_pkg::SHIFT_DR;
      jsd_pkg::SHIFT_DR: nxt_state = tms ? jsd_pkg::EXIT1_DR : jsd_pkg::SHIFT_DR;
      jsd_pkg::EXIT1_DR: nxt_state = tms ? jsd_pkg::UPD_DR : jsd_pkg::PAUSE_DR;
      jsd_pkg::PAUSE_DR: nxt_state = tms ? jsd_pkg::EXIT2_DR : jsd_pkg::PAUSE_DR;
      jsd_pkg::EXIT2_DR: nxt_state = tms ? jsd_pkg::UPD_DR : jsd_pkg::SHIFT_DR;
      jsd_pkg::UPD_DR: nxt_state = tms ? jsd_pkg::SEL_DR : jsd_pkg::RUN_IDLE;
      jsd_pkg::SEL_IR: nxt_state = tms ? jsd_pkg::TEST_RESET : jsd_pkg::CAP_IR;
      jsd_pkg::CAP_IR: nxt_state = tms ? jsd_pkg::EXIT1_IR : jsd_pkg::SHIFT_IR;
      jsd_pkg::SHIFT_IR: nxt_state = tms ? jsd_pkg::EXIT1_IR : jsd_pkg::SHIFT_IR;
      jsd_pkg::EXIT1_IR: nxt_state = tms ? jsd_pkg::UPD_IR : jsd_pkg::PAUSE_IR;
      jsd_pkg::PAUSE_IR: nxt_state = tms ? jsd_pkg::EXIT2_IR : jsd_pkg::PAUSE_IR;
      jsd_pkg::EXIT2_IR: nxt_state = tms ? jsd_pkg::UPD_IR : jsd_pkg::SHIFT_IR;
      jsd_pkg::UPD_IR: nxt_state = tms ? jsd_pkg::SEL_DR : jsd_pkg::RUN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= jsd_pkg::TEST_RESET;
    end else if (!trst_sync_n) begin
      state <= jsd_pkg::TEST_RESET;
    end else if (tck_rise) begin
      state <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ir_sh_ff <= '0;
      ir <= `JSD_IR_RESET;
    end else if (!trst_sync_n || state == jsd_pkg::TEST_RESET) begin
      ir <= `JSD_IR_RESET;
    end else if (tck_rise) begin
      if (state == jsd_pkg::CAP_IR) begin
        ir_sh_ff <= `JSD_IR_CAPTURE;
      end else if (state == jsd_pkg::SHIFT_IR) begin
        ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]};
      end else if (state == jsd_pkg::UPD_IR) begin
        ir <= ir_sh_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // data registers
  // ------------------------------------------------------------
  assign long_sel = (ir == `JSD_OP_IDCODE) || (ir == `JSD_OP_USERCODE) ||
                    (ir == `JSD_OP_EXTEST) || (ir == `JSD_OP_SAMPLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dr_sh_ff <= '0;
      byp_ff <= 1'b0;
      bscan_upd <= '0;
    end else if (!trst_sync_n) begin
      bscan_upd <= '0;
    end else if (tck_rise) begin
      if (state == jsd_pkg::CAP_DR) begin
        byp_ff <= 1'b0;
        unique case (ir)
          `JSD_OP_IDCODE: dr_sh_ff <= idcode;
          `JSD_OP_USERCODE: dr_sh_ff <= usercode;
          default: dr_sh_ff <= bscan_cap;
        endcase
      end else if (state == jsd_pkg::SHIFT_DR) begin
        dr_sh_ff <= {tdi, dr_sh_ff[DR_W-1:1]};
        byp_ff <= tdi;
      end else if (state == jsd_pkg::UPD_DR && ir == `JSD_OP_EXTEST) begin
        bscan_upd <= dr_sh_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // serial output, changes on the falling test clock
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!trst_sync_n) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (state == jsd_pkg::SHIFT_DR) || (state == jsd_pkg::SHIFT_IR);
      if (state == jsd_pkg::SHIFT_IR) begin
        tdo <= ir_sh_ff[0];
      end else if (ir == `JSD_OP_CHIP) begin
        tdo <= chip_tdo;
      end else begin
        tdo <= long_sel ? dr_sh_ff[0] : byp_ff;
      end
    end
  end
endmodule // jsd_tap

// ===== tb/jsd_host.sv
// test host model driving the scan pins
`timescale 1ns/1ns
module jsd_host (
  // scan pins
  output jsd_pkg::jsd_scan_in_t scan_in,
  output logic trst_n,
  input wire jsd_pkg::jsd_scan_out_t scan_out
);
  initial begin
    scan_in = '0;
    trst_n = 1'b0;
    #200 trst_n = 1'b1;
  end
  // tdo is taken late in the high phase: the port answers about four clocks after a fall
  task automatic bit_x(input logic ms, input logic di, output logic dq);
    scan_in.tck = 1'b0;
    scan_in.tms = ms;
    scan_in.tdi = di;
    #160 scan_in.tck = 1'b1;
    #160 dq = scan_out.tdo;
  endtask
  task automatic tlr();
    logic d;
    // keep pin changes off the clock edges
    #13;
    for (int i = 0; i < 6; i++) bit_x(i < 5, 1'b0, d);
  endtask
  task automatic trst_pulse();
    trst_n = 1'b0;
    #400 trst_n = 1'b1;
  endtask
  // from idle to shift, n bits lsb first, then update and back to idle
  task automatic scan(input logic ir_sel, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic d;
    dout = '0;
    #13;
    for (int i = 0; i < 3 + ir_sel; i++) bit_x(i == 0 || (i == 1 && ir_sel), 1'b0, d);
    for (int i = 0; i < n; i++) bit_x(i == n - 1, din[i], dout[i]);
    bit_x(1'b1, 1'b0, d);
    bit_x(1'b0, 1'b0, d);
  endtask
endmodule // jsd_host

// ===== tb/jsd_port_bench.sv
// self-checking bench of the scan and debug port
`timescale 1ns/1ns
module jsd_port_bench;
  localparam logic [10:0] MAKER = 11'h155; // arbitrary value
  localparam logic [15:0] PART = 16'hA5C3; // arbitrary value
  localparam logic [3:0] VER = 4'h2; // arbitrary value
  localparam logic [15:0] REV = 16'h0042;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  jsd_pkg::jsd_scan_in_t scan_in;
  jsd_pkg::jsd_scan_out_t scan_out;
  logic trst_n, otp_programmed, chip_tdo, chip_sel, chip_tms, chip_tdi, chip_tck, ext_low;
  logic dbg_out, dbg_oe, dbg_cfg_out, dbg_cfg_en, brk_hit, dbg_enter;
  logic [31:0] sec_reg, pins_cap_a, pins_cap_b, pins_drv_a, pins_drv_b, sd;
  logic [3:0] ir_a, ir_b;
  logic [63:0] din, dout, exp_v;
  logic [7:0] ops [7] = '{8'h13, 8'h33, 8'h33, 8'h22, 8'hF7, 8'h2F, 8'h00};
  int error_cnt = 0;
  int tests_run = 0;
  // open drain pin with a pull-up
  wire logic dbg_pin = (dbg_oe || ext_low) ? 1'b0 : 1'b1;
  always #20 clk = ~clk;
  jsd_port #(.MAKER_ID(MAKER), .PART_NUM(PART), .VERSION(VER), .SILICON_REV(REV)) dut_u (
    .clk(clk), .rstn(rstn), .scan_in(scan_in), .trst_n(trst_n), .scan_out(scan_out), .sec_reg(sec_reg),
    .otp_programmed(otp_programmed), .pins_cap_a(pins_cap_a), .pins_cap_b(pins_cap_b),
    .pins_drv_a(pins_drv_a), .pins_drv_b(pins_drv_b), .ir_a(ir_a), .ir_b(ir_b), .chip_tdo(chip_tdo),
    .chip_sel(chip_sel), .chip_tms(chip_tms), .chip_tdi(chip_tdi), .chip_tck(chip_tck), .dbg_in(dbg_pin),
    .dbg_out(dbg_out), .dbg_oe(dbg_oe), .dbg_cfg_out(dbg_cfg_out), .dbg_cfg_en(dbg_cfg_en),
    .brk_hit(brk_hit), .dbg_enter(dbg_enter));
  jsd_host host_u (.scan_in(scan_in), .trst_n(trst_n), .scan_out(scan_out));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [31:0] model(input logic [3:0] op, input logic [31:0] cap);
    if (op == 4'h1) return {VER, PART, MAKER, 1'b1};
    if (op == 4'h3) return {otp_programmed ? sec_reg[31:22] : 10'h000, 6'h00, REV};
    return cap;
  endfunction
  // bypass for every unknown code: a single zero-capture cell
  function automatic void push(input logic [3:0] op, input logic [31:0] cap, ref logic q[$]);
    logic [31:0] w;
    w = model(op, cap);
    if (op > 4'h4) q.push_back(1'b0);
    else for (int i = 0; i < 32; i++) q.push_back(w[i]);
  endfunction
  task automatic ld(input logic [3:0] a, input logic [3:0] b);
    host_u.scan(1'b1, 8, {56'h0, a, b}, dout);
    chk(dout[7:0] === 8'h11, "instruction capture");
    chk(ir_a === a && ir_b === b, "instruction update");
  endtask
  task automatic dr(input logic [7:0] ab);
    logic q[$];
    @(posedge clk);
    pins_cap_a <= $urandom;
    pins_cap_b <= $urandom;
    sec_reg <= $urandom & 32'hFFFFBFFE;
    otp_programmed <= ~otp_programmed;
    ld(ab[7:4], ab[3:0]);
    din = {$urandom, $urandom};
    push(ab[3:0], pins_cap_b, q);
    push(ab[7:4], pins_cap_a, q);
    for (int i = 0; i < 64; i++) q.push_back(din[i]);
    for (int i = 0; i < 64; i++) exp_v[i] = q[i];
    host_u.scan(1'b0, 64, din, dout);
    chk(dout === exp_v, "data register");
    if (ab == 8'h00) chk(pins_drv_a === din[63:32] && pins_drv_b === din[31:0], "pin update");
  endtask
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    sd = $urandom(91023);
    {sec_reg, pins_cap_a, pins_cap_b} = '0;
    {otp_programmed, chip_tdo, ext_low, dbg_cfg_out, dbg_cfg_en, brk_hit} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wait (trst_n === 1'b1);
    host_u.tlr();
    chk(ir_a === 4'h1 && ir_b === 4'h1 && dbg_oe === 1'b0, "reset state");
    din = {$urandom, $urandom};
    host_u.scan(1'b0, 64, din, dout);
    chk(dout === {2{VER, PART, MAKER, 1'b1}}, "default identification");
    ld(4'h3, 4'h3);
    host_u.trst_pulse();
    chk(ir_a === 4'h1 && ir_b === 4'h1, "test reset");
    host_u.tlr();
    @(posedge clk);
    sec_reg <= 32'h00000001;
    host_u.scan(1'b1, 8, 64'h33, dout);
    chk(ir_a === 4'h1 && scan_out.tdo_oe === 1'b0, "port disabled");
    @(posedge clk);
    sec_reg <= 32'h00000000;
    host_u.tlr();
    ld(4'h4, 4'hF);
    chk(chip_sel === 1'b1, "chip port selected");
    @(posedge clk);
    chip_tdo <= 1'b1;
    host_u.scan(1'b0, 8, 64'h0, dout);
    chk(dout[7:0] === 8'hFE, "chip port data");
    chk(chip_tck === 1'b1 && chip_tms === 1'b0 && chip_tdi === 1'b0, "chip port pins");
    foreach (ops[i]) dr(ops[i]);
    @(posedge clk);
    dbg_cfg_en <= 1'b1;
    dbg_cfg_out <= 1'b1;
    wt(4);
    chk(dbg_oe === 1'b0, "floating before breakpoint");
    @(posedge clk);
    brk_hit <= 1'b1;
    @(posedge clk);
    brk_hit <= 1'b0;
    wt(4);
    chk(dbg_oe === 1'b1 && dbg_out === 1'b0, "driven low at breakpoint");
    @(posedge clk);
    dbg_cfg_out <= 1'b0;
    ext_low <= 1'b1;
    wt(6);
    chk(dbg_oe === 1'b0 && dbg_enter === 1'b1, "debug entry from pin");
    @(posedge clk);
    sec_reg <= 32'h00004000;
    wt(6);
    chk(dbg_enter === 1'b0 && dbg_oe === 1'b0, "sync pin blocked");
    report_and_stop();
  end
endmodule // jsd_port_bench

// ===== tb/jsd_port_checker.sv
// assertions on the pins of the scan and debug port
`timescale 1ns/1ns
module jsd_port_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched pins
  input wire logic trst_n,
  input wire jsd_pkg::jsd_scan_out_t scan_out,
  input wire logic [31:0] sec_reg,
  input wire logic [31:0] pins_drv_a,
  input wire logic [3:0] ir_a,
  input wire logic [3:0] ir_b,
  input wire logic chip_sel,
  input wire logic dbg_out,
  input wire logic dbg_oe,
  input wire logic dbg_cfg_out,
  input wire logic dbg_cfg_en,
  input wire logic dbg_enter
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sync_low_a: assert property (dbg_out == 1'b0)
    else $error("sync pin driven high");
  drive_cause_a: assert property ($rose(dbg_oe) |-> dbg_cfg_en && dbg_cfg_out && !sec_reg[14])
    else $error("sync pin driven without output mode");
  entry_cause_a: assert property ($rose(dbg_enter) |-> dbg_cfg_en && !dbg_cfg_out)
    else $error("debug entry outside input mode");
  sync_block_a: assert property (sec_reg[14] [*4] |-> !dbg_oe && !dbg_enter)
    else $error("sync pin not blocked");
  trst_hold_a: assert property (!trst_n [*6] |-> ir_a == 4'h1 && ir_b == 4'h1)
    else $error("ports not held in reset");
  port_off_a: assert property (sec_reg[0] [*6] |-> ir_a == 4'h1 && !scan_out.tdo_oe)
    else $error("disabled port active");
  chip_path_a: assert property ($past(ir_a) == 4'h4 && ir_a == 4'h4 |-> chip_sel)
    else $error("chip port not selected");
  drv_update_a: assert property ($changed(pins_drv_a) |-> $past(ir_a) == 4'h0)
    else $error("pin drive changed outside extest");
  float_input_a: assert property (!dbg_cfg_en [*4] |-> !dbg_oe)
    else $error("sync pin driven while disabled");
  breakpoint_c: cover property ($rose(dbg_oe));
  chip_sel_c: cover property ($rose(chip_sel));
  shift_c: cover property ($rose(scan_out.tdo_oe));
endmodule // jsd_port_checker
bind jsd_port jsd_port_checker chk_u (.clk(clk), .rstn(rstn), .trst_n(trst_n), .scan_out(scan_out),
  .sec_reg(sec_reg), .pins_drv_a(pins_drv_a), .ir_a(ir_a), .ir_b(ir_b), .chip_sel(chip_sel),
  .dbg_out(dbg_out), .dbg_oe(dbg_oe), .dbg_cfg_out(dbg_cfg_out), .dbg_cfg_en(dbg_cfg_en), .dbg_enter(dbg_enter));
